// ==== hdl/shc_pkg.sv ====
// Purpose: constants and types for the serial host/client register block
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   one package shared by the design and the bench
package shc_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [2:0] SHC_OFS_CONTROL_A = 3'h0;
  localparam logic [2:0] SHC_OFS_CONTROL_B = 3'h1;
  localparam logic [2:0] SHC_OFS_IRQ_EN    = 3'h2;
  localparam logic [2:0] SHC_OFS_FLAGS     = 3'h3;
  localparam logic [2:0] SHC_OFS_DATA      = 3'h4;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SHC_A_ENABLE   = 0;
  localparam int SHC_A_DIV_LO   = 1;
  localparam int SHC_A_DOUBLE   = 4;
  localparam int SHC_A_HOST     = 5;
  localparam int SHC_A_LSB      = 6;
  localparam int SHC_B_MODE_LO  = 0;
  localparam int SHC_B_SEL_IGN  = 2;
  localparam int SHC_B_WAIT_RX  = 6;
  localparam int SHC_B_BUF_EN   = 7;
  localparam int SHC_F_DONE     = 7;
  localparam int SHC_F_WCOL     = 6;
  localparam int SHC_F_RXC      = 7;
  localparam int SHC_F_TXC      = 6;
  localparam int SHC_F_DRE      = 5;
  localparam int SHC_F_SSI      = 4;
  localparam int SHC_F_OVF      = 0;
  localparam int SHC_E_NORMAL   = 0;
  // ----------------------------------------------------------------
  // reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] SHC_RST_CONTROL_A = 8'h00;
  localparam logic [7:0] SHC_RST_CONTROL_B = 8'h00;
  localparam logic [7:0] SHC_RST_IRQ_EN    = 8'h00;
  localparam logic [7:0] SHC_RST_DATA      = 8'h00;
  localparam logic [7:0] SHC_MASK_A        = 8'h77;
  localparam logic [7:0] SHC_MASK_B        = 8'hC7;
  localparam logic [7:0] SHC_MASK_E        = 8'hF1;
  // ----------------------------------------------------------------
  // timing: half serial period in system clocks per divider code
  // ----------------------------------------------------------------
  localparam logic [6:0] SHC_HALF_DIVIDE_BY_FOUR   = 7'h02;
  localparam logic [6:0] SHC_HALF_DIVIDE_BY_SIXTEEN  = 7'h08;
  localparam logic [6:0] SHC_HALF_DIVIDE_BY_SIXTY_FOUR  = 7'h20;
  localparam logic [6:0] SHC_HALF_DIVIDE_BY_ONE_TWENTY_EIGHT = 7'h40;

  typedef enum logic [1:0] {
    SHC_IDLE,
    SHC_LEAD,
    SHC_TRAIL
  } shc_phase_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } shc_bus_req_t;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
  } shc_pins_out_t;

  typedef struct packed {
    logic sclk_i;
    logic mosi_i;
    logic miso_i;
    logic sel_n_i;
  } shc_pins_in_t;

  typedef struct packed {
    logic [7:0]    ctrl_a;
    logic [7:0]    ctrl_b;
    logic [7:0]    irq_en;
    logic          done;
    logic          wcol;
    logic          armed;
    logic          rxc;
    logic          txc;
    logic          dre;
    logic          ssi;
    logic          ovf;
    logic [7:0]    shift;
    logic [7:0]    rx_reg;
    logic [7:0]    rx_buf;
    logic          rx_buf_full;
    logic          rx_reg_full;
    logic [7:0]    tx_buf;
    logic          pend;
    logic          primed;
    logic [2:0]    bit_cnt;
    logic          busy;
    shc_phase_t    phase;
    logic [6:0]    div_cnt;
    logic          sclk_q;
    logic          sel_q;
    logic          sample_bit;
    logic [7:0]    rdata;
    logic          irq;
    shc_pins_out_t pins;
  } shc_state_t;
endpackage

// ==== hdl/shc_top.sv ====
// Purpose: control, status and shifting for a byte serial host/client
// Assumes: pins sampled synchronously to clk_sys; 8-bit register port
// Notes:   select pin is always treated as an input
//
// Notes on behaviour
// - bit order control picks MSB or LSB first
// - host bit chooses host or client role
// - select low in host drops role, sets done (ssi in buffer mode)
// - select ignore keeps host role on select low
// - clock double halves the serial period
// - divider codes give 4, 16, 64, 128
// - buffer mode adds two rx stages, one tx
// - wait bit 0: first byte out is dummy
// - wait bit 1: first idle write after enable loads shifter directly
// - mode field chooses sample and setup edges
// - serial clock idles at leading edge opposite
// - four buffered enables, read zero otherwise
// - normal enable gates done onto interrupt
// - done sets on byte end or select fault
// - done clears by vector ack or read-then-data
// - collision sets on data write while busy
// - collision clears by flag read then data
// - data port maps by mode to shifter or buffers
// - overflow on third byte, clear read or one
// - tx empty high when buffer holds nothing
// - rx complete follows unread data, writing one does not clear it
`timescale 1ns/100ps
`default_nettype none
module shc_top
  import shc_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          reset,
  input  wire shc_bus_req_t  bus_req,
  output var  logic [7:0]    bus_rdata,
  input  wire logic          irq_ack,
  output var  logic          irq,
  input  wire shc_pins_in_t  pins_in,
  output var  shc_pins_out_t pins_out
);
  shc_state_t st_ff;
  shc_state_t nxt_st;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [6:0] half_period(input logic [1:0] code,
                                             input logic       dbl);
    logic [6:0] h;
    h = SHC_HALF_DIVIDE_BY_FOUR;
    case (code)
      2'h0: h = SHC_HALF_DIVIDE_BY_FOUR;
      2'h1: h = SHC_HALF_DIVIDE_BY_SIXTEEN;
      2'h2: h = SHC_HALF_DIVIDE_BY_SIXTY_FOUR;
      default: h = SHC_HALF_DIVIDE_BY_ONE_TWENTY_EIGHT;
    endcase
    if (dbl) begin
      h = h >> 1;
    end
    return h;
  endfunction

  function automatic logic out_bit(input logic [7:0] s, input logic lsb);
    return lsb ? s[0] : s[7];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] s,
                                          input logic lsb,
                                          input logic b);
    return lsb ? {b, s[7:1]} : {s[6:0], b};
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       en;
    logic       host;
    logic       bufm;
    logic       lsb;
    logic [1:0] mode;
    logic       cpha;
    logic       cpol;
    logic       wr_d;
    logic       rd_d;
    logic       sel_n;
    logic       lead;
    logic       trail;
    logic       sample_e;
    logic       setup_e;
    logic       byte_end;
    logic       in_bit;
    logic       fault;
    logic [7:0] rnext;
    en = 1'b0;
    host = 1'b0;
    bufm = 1'b0;
    lsb = 1'b0;
    mode = 2'h0;
    cpha = 1'b0;
    cpol = 1'b0;
    wr_d = 1'b0;
    rd_d = 1'b0;
    sel_n = 1'b1;
    lead = 1'b0;
    trail = 1'b0;
    sample_e = 1'b0;
    setup_e = 1'b0;
    byte_end = 1'b0;
    in_bit = 1'b0;
    fault = 1'b0;
    rnext = 8'h00;
    nxt_st = st_ff;

    en    = st_ff.ctrl_a[SHC_A_ENABLE];
    host  = st_ff.ctrl_a[SHC_A_HOST];
    lsb   = st_ff.ctrl_a[SHC_A_LSB];
    bufm  = st_ff.ctrl_b[SHC_B_BUF_EN];
    mode  = st_ff.ctrl_b[SHC_B_MODE_LO +: 2];
    cpha  = mode[0];
    cpol  = mode[1];
    sel_n = pins_in.sel_n_i;
    wr_d  = bus_req.wr && bus_req.addr == SHC_OFS_DATA;
    rd_d  = bus_req.rd && bus_req.addr == SHC_OFS_DATA;
    nxt_st.sel_q  = sel_n;
    nxt_st.sclk_q = pins_in.sclk_i;

    // --------------------------------------------------------------
    // serial engine
    // --------------------------------------------------------------
    if (!en) begin
      nxt_st.busy    = 1'b0;
      nxt_st.phase   = SHC_IDLE;
      nxt_st.bit_cnt = 3'h0;
      nxt_st.primed  = 1'b0;
    end else if (host) begin
      if (st_ff.phase != SHC_IDLE) begin
        if (st_ff.div_cnt <= 7'h01) begin
          nxt_st.div_cnt = half_period(st_ff.ctrl_a[SHC_A_DIV_LO +: 2],
                                       st_ff.ctrl_a[SHC_A_DOUBLE]);
          if (st_ff.phase == SHC_LEAD) begin
            lead = 1'b1;
            nxt_st.phase = SHC_TRAIL;
          end else begin
            trail = 1'b1;
            nxt_st.phase = (st_ff.bit_cnt == 3'h7) ? SHC_IDLE : SHC_LEAD;
          end
        end else begin
          nxt_st.div_cnt = st_ff.div_cnt - 7'h01;
        end
      end else if (st_ff.busy) begin
        nxt_st.phase   = SHC_LEAD;
        nxt_st.div_cnt = half_period(st_ff.ctrl_a[SHC_A_DIV_LO +: 2],
                                     st_ff.ctrl_a[SHC_A_DOUBLE]);
      end
      in_bit = pins_in.miso_i;
    end else begin
      lead  = !sel_n && st_ff.sclk_q == cpol && pins_in.sclk_i != cpol;
      trail = !sel_n && st_ff.sclk_q != cpol && pins_in.sclk_i == cpol;
      in_bit = pins_in.mosi_i;
      if (sel_n) begin
        nxt_st.bit_cnt = 3'h0;
        nxt_st.busy    = 1'b0;
      end else if (!st_ff.busy) begin
        nxt_st.busy = 1'b1;
      end
    end
    sample_e = cpha ? trail : lead;
    setup_e  = cpha ? lead : trail;
    if (sample_e) begin
      nxt_st.sample_bit = in_bit;
    end
    if (setup_e && !(cpha && st_ff.bit_cnt == 3'h0 && lead)) begin
      nxt_st.shift = shift_in(st_ff.shift, lsb, st_ff.sample_bit);
    end
    // last trailing edge ends the byte in every mode, so with the phase bit
    // set the data line moves on the edge at which the far side samples it
    if (trail) begin
      if (st_ff.bit_cnt == 3'h7) begin
        byte_end = 1'b1;
      end
      nxt_st.bit_cnt = st_ff.bit_cnt + 3'h1;
    end
    if (byte_end) begin
      rnext = shift_in(st_ff.shift, lsb,
                       cpha ? in_bit : st_ff.sample_bit);
      nxt_st.shift = rnext;
      nxt_st.busy  = !host;
      nxt_st.rx_reg = rnext;
    end

    // --------------------------------------------------------------
    // select fault fallback
    // --------------------------------------------------------------
    fault = en && host && !sel_n && !st_ff.ctrl_b[SHC_B_SEL_IGN];
    if (fault) begin
      nxt_st.ctrl_a[SHC_A_HOST] = 1'b0;
      nxt_st.phase = SHC_IDLE;
      nxt_st.busy  = 1'b0;
      nxt_st.bit_cnt = 3'h0;
    end

    // --------------------------------------------------------------
    // flag clears from register port, then hardware sets win
    // --------------------------------------------------------------
    if (bus_req.rd && bus_req.addr == SHC_OFS_FLAGS) begin
      nxt_st.armed = st_ff.done || st_ff.wcol;
    end else if (bus_req.wr || bus_req.rd) begin
      nxt_st.armed = 1'b0;
    end
    if ((wr_d || rd_d) && st_ff.armed) begin
      nxt_st.done = 1'b0;
      nxt_st.wcol = 1'b0;
    end
    if (irq_ack && !bufm) begin
      nxt_st.done = 1'b0;
    end
    if (bus_req.wr && bus_req.addr == SHC_OFS_FLAGS && bufm) begin
      if (bus_req.wdata[SHC_F_RXC]) nxt_st.rxc = 1'b0;
      if (bus_req.wdata[SHC_F_TXC]) nxt_st.txc = 1'b0;
      if (bus_req.wdata[SHC_F_SSI]) nxt_st.ssi = 1'b0;
      if (bus_req.wdata[SHC_F_OVF]) nxt_st.ovf = 1'b0;
    end

    // --------------------------------------------------------------
    // data port
    // --------------------------------------------------------------
    if (!bufm) begin
      if (wr_d) begin
        if (st_ff.busy || st_ff.phase != SHC_IDLE) begin
          nxt_st.wcol = 1'b1;
        end else begin
          nxt_st.shift = bus_req.wdata;
          nxt_st.busy  = host && en;
        end
      end
      if (byte_end || fault) begin
        nxt_st.done = 1'b1;
      end
    end else begin
      if (rd_d) begin
        nxt_st.rx_buf      = st_ff.rx_reg;
        nxt_st.rx_buf_full = st_ff.rx_reg_full;
        nxt_st.rx_reg_full = 1'b0;
        nxt_st.ovf         = 1'b0;
      end
      if (wr_d) begin
        if (st_ff.ctrl_b[SHC_B_WAIT_RX] && en && sel_n && !st_ff.primed
            && !st_ff.busy && st_ff.phase == SHC_IDLE) begin
          nxt_st.shift  = bus_req.wdata;
          nxt_st.primed = 1'b1;
          nxt_st.busy   = host;
        end else if (st_ff.dre) begin
          nxt_st.tx_buf = bus_req.wdata;
          nxt_st.pend   = 1'b1;
          nxt_st.dre    = 1'b0;
          // idle host starts a dummy byte so the buffer drains
          if (!st_ff.busy && st_ff.phase == SHC_IDLE) begin
            nxt_st.busy = host && en;
          end
        end
      end
      if (byte_end) begin
        if (st_ff.rx_buf_full && st_ff.rx_reg_full) begin
          nxt_st.ovf = 1'b1;
        end else if (!nxt_st.rx_buf_full) begin
          nxt_st.rx_buf      = rnext;
          nxt_st.rx_buf_full = 1'b1;
        end else begin
          nxt_st.rx_reg_full = 1'b1;
        end
        if (st_ff.pend) begin
          nxt_st.shift = st_ff.tx_buf;
          nxt_st.pend  = 1'b0;
          nxt_st.dre   = 1'b1;
          nxt_st.busy  = 1'b1;
        end else begin
          nxt_st.txc = 1'b1;
        end
      end
      nxt_st.rxc = nxt_st.rx_buf_full;
      if (fault) begin
        nxt_st.ssi = 1'b1;
      end
    end

    // --------------------------------------------------------------
    // register writes
    // --------------------------------------------------------------
    if (bus_req.wr) begin
      case (bus_req.addr)
        SHC_OFS_CONTROL_A: begin
          nxt_st.ctrl_a = bus_req.wdata & SHC_MASK_A;
          if (fault && bus_req.wdata[SHC_A_HOST]) begin
            nxt_st.ctrl_a[SHC_A_HOST] = 1'b0;
          end
        end
        SHC_OFS_CONTROL_B: nxt_st.ctrl_b = bus_req.wdata & SHC_MASK_B;
        SHC_OFS_IRQ_EN:    nxt_st.irq_en = bus_req.wdata & SHC_MASK_E;
        default: ;
      endcase
    end

    // --------------------------------------------------------------
    // read data, one cycle later
    // --------------------------------------------------------------
    nxt_st.rdata = 8'h00;
    if (bus_req.rd) begin
      case (bus_req.addr)
        SHC_OFS_CONTROL_A: nxt_st.rdata = st_ff.ctrl_a;
        SHC_OFS_CONTROL_B: nxt_st.rdata = st_ff.ctrl_b;
        SHC_OFS_IRQ_EN: begin
          nxt_st.rdata = bufm ? st_ff.irq_en
                              : (st_ff.irq_en & 8'h01);
        end
        SHC_OFS_FLAGS: begin
          if (bufm) begin
            nxt_st.rdata = {st_ff.rxc, st_ff.txc, st_ff.dre, st_ff.ssi,
                            3'h0, st_ff.ovf};
          end else begin
            nxt_st.rdata = {st_ff.done, st_ff.wcol, 6'h00};
          end
        end
        SHC_OFS_DATA: nxt_st.rdata = bufm ? st_ff.rx_buf : st_ff.rx_reg;
        default: nxt_st.rdata = 8'h00;
      endcase
    end

    // --------------------------------------------------------------
    // interrupt and pins
    // --------------------------------------------------------------
    if (bufm) begin
      nxt_st.irq = (nxt_st.rxc && st_ff.irq_en[SHC_F_RXC]) ||
                   (nxt_st.txc && st_ff.irq_en[SHC_F_TXC]) ||
                   (nxt_st.dre && st_ff.irq_en[SHC_F_DRE]) ||
                   (nxt_st.ssi && st_ff.irq_en[SHC_F_SSI]);
    end else begin
      nxt_st.irq = nxt_st.done && st_ff.irq_en[SHC_E_NORMAL];
    end
    nxt_st.pins.sclk_oe = en && nxt_st.ctrl_a[SHC_A_HOST];
    nxt_st.pins.sclk_o  = cpol ^ (nxt_st.phase == SHC_TRAIL);
    nxt_st.pins.mosi_oe = en && nxt_st.ctrl_a[SHC_A_HOST];
    nxt_st.pins.mosi_o  = out_bit(nxt_st.shift, lsb);
    nxt_st.pins.miso_oe = en && !nxt_st.ctrl_a[SHC_A_HOST] && !sel_n;
    nxt_st.pins.miso_o  = out_bit(nxt_st.shift, lsb);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_ff        <= '0;
      st_ff.ctrl_a <= SHC_RST_CONTROL_A;
      st_ff.ctrl_b <= SHC_RST_CONTROL_B;
      st_ff.irq_en <= SHC_RST_IRQ_EN;
      st_ff.shift  <= SHC_RST_DATA;
      st_ff.dre    <= 1'b1;
      st_ff.sel_q  <= 1'b1;
      st_ff.phase  <= SHC_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus_rdata = st_ff.rdata;
  assign irq       = st_ff.irq;
  assign pins_out  = st_ff.pins;
endmodule
`default_nettype wire

// ==== tb/shc_properties.sv ====
// Purpose: port assertions for shc_top
// Assumes: control registers shadowed from bus writes
// Notes:   bound into shc_top
`timescale 1ns/100ps
`default_nettype none
module shc_properties
  import shc_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          reset,
  input wire shc_bus_req_t  bus_req,
  input wire logic [7:0]    bus_rdata,
  input wire logic          irq_ack,
  input wire logic          irq,
  input wire shc_pins_in_t  pins_in,
  input wire shc_pins_out_t pins_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // shadow registers
  // ----------------------------------------------------------------
  logic [7:0] a_ff;
  logic [7:0] b_ff;
  logic [7:0] e_ff;
  logic [6:0] cnt_ff;
  logic [6:0] half_w;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      a_ff   <= 8'h00;
      b_ff   <= 8'h00;
      e_ff   <= 8'h00;
      cnt_ff <= 7'h7F;
    end else begin
      if (bus_req.wr) begin
        case (bus_req.addr)
          SHC_OFS_CONTROL_A: a_ff <= bus_req.wdata;
          SHC_OFS_CONTROL_B: b_ff <= bus_req.wdata;
          SHC_OFS_IRQ_EN:    e_ff <= bus_req.wdata;
          default: ;
        endcase
      end
      if ($changed(pins_out.sclk_o)) cnt_ff <= 7'h01;
      else if (cnt_ff != 7'h7F) cnt_ff <= cnt_ff + 7'h01;
    end
  end
  always_comb begin
    case (a_ff[2:1])
      2'h0: half_w = SHC_HALF_DIVIDE_BY_FOUR;
      2'h1: half_w = SHC_HALF_DIVIDE_BY_SIXTEEN;
      2'h2: half_w = SHC_HALF_DIVIDE_BY_SIXTY_FOUR;
      default: half_w = SHC_HALF_DIVIDE_BY_ONE_TWENTY_EIGHT;
    endcase
    if (a_ff[4]) half_w = half_w >> 1;
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_ack;
    irq_ack && !b_ff[7];
  endsequence
  sequence s_trail;
    $changed(pins_out.sclk_o) && pins_out.sclk_oe &&
      pins_out.sclk_o == b_ff[1] && b_ff == $past(b_ff, 3);
  endsequence
  chk_rdata_idle: assert property
    (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data outside read cycle");
  chk_unmapped_zero: assert property
    (bus_req.rd && bus_req.addr > 3'h4 |=> bus_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_ctrl_a_read: assert property
    (bus_req.rd && bus_req.addr == SHC_OFS_CONTROL_A |=>
      (bus_rdata & 8'h57) == ($past(a_ff) & 8'h57))
    else $error("control a readback wrong");
  chk_enable_read: assert property
    (bus_req.rd && bus_req.addr == SHC_OFS_IRQ_EN |=> bus_rdata ==
      ($past(e_ff) & ($past(b_ff[7]) ? SHC_MASK_E : 8'h01)))
    else $error("enable readback wrong");
  chk_disabled_clock: assert property
    (!a_ff[0] && !$past(a_ff[0]) |-> !pins_out.sclk_oe)
    else $error("clock driven while disabled");
  chk_idle_level: assert property
    ($rose(pins_out.sclk_oe) |-> pins_out.sclk_o == b_ff[1])
    else $error("clock idle level wrong");
  chk_trail_spacing: assert property
    (s_trail |-> cnt_ff == half_w)
    else $error("half period wrong");
  chk_ack_clears: assert property
    (s_ack |-> ##[1:2] !irq)
    else $error("acknowledge did not clear request");
  chk_irq_enabled: assert property
    ($rose(irq) |-> e_ff != 8'h00)
    else $error("request without enable");
  chk_role_drive: assert property
    (pins_out.miso_oe |-> !pins_out.sclk_oe && !$past(pins_in.sel_n_i))
    else $error("host and client drive together");
  cover property (s_trail);
endmodule
bind shc_top shc_properties u_props (
  .clk_sys(clk_sys), .reset(reset), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .irq_ack(irq_ack), .irq(irq),
  .pins_in(pins_in), .pins_out(pins_out));
`default_nettype wire

// ==== tb/shc_client_model.sv ====
// Purpose: far-side serial client, mode 0, msb first
// Assumes: loaded with a byte before each transfer
// Notes:   undriven clock shows inverse data on the line
`timescale 1ns/100ps
`default_nettype none
module shc_client_model (
  input  wire logic       sclk,
  input  wire logic       sclk_oe,
  input  wire logic       mosi,
  input  wire logic       load,
  input  wire logic [7:0] tx_byte,
  output var  logic       miso,
  output var  logic [7:0] rx_byte
);
  logic [7:0] sh_ff = 8'h00;
  initial rx_byte = 8'h00;
  always @(posedge sclk) begin
    if (sclk_oe) rx_byte <= {rx_byte[6:0], mosi};
  end
  always @(posedge load or negedge sclk) begin
    if (load) sh_ff <= tx_byte;
    else if (sclk_oe) sh_ff <= {sh_ff[6:0], 1'b0};
  end
  always_comb miso = sclk_oe ? sh_ff[7] : ~sh_ff[7];
endmodule
`default_nettype wire

// ==== tb/test_shc_top.sv ====
// Purpose: self-checking bench for shc_top
// Assumes: far side is a mode 0 client model
// Notes:   expectations from bit order and divider rules
`timescale 1ns/100ps
`default_nettype none
module test_shc_top;
  import shc_pkg::*;
  logic          clk_sys = 1'b0;
  logic          reset   = 1'b1;
  shc_bus_req_t  bus_req = '0;
  logic [7:0]    bus_rdata;
  logic          irq_ack = 1'b0;
  logic          irq;
  shc_pins_in_t  pins_in;
  shc_pins_out_t pins_out;
  logic          sel_n   = 1'b1;
  logic          load    = 1'b0;
  logic [7:0]    peer_tx = 8'h00;
  logic [7:0]    peer_rx;
  logic          peer_miso;
  logic [7:0]    rv;
  logic [7:0]    exp_q[$];
  int            fails   = 0;
  int            checks  = 0;
  int            cycles  = 0;
  always #2 clk_sys = ~clk_sys;
  assign pins_in = '{sclk_i: pins_out.sclk_o, mosi_i: pins_out.mosi_o,
                     miso_i: peer_miso, sel_n_i: sel_n};
  shc_top DUT (.clk_sys(clk_sys), .reset(reset), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .irq_ack(irq_ack), .irq(irq),
    .pins_in(pins_in), .pins_out(pins_out));
  shc_client_model peer (.sclk(pins_out.sclk_o),
    .sclk_oe(pins_out.sclk_oe), .mosi(pins_out.mosi_o), .load(load),
    .tx_byte(peer_tx), .miso(peer_miso), .rx_byte(peer_rx));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    tick(1);
    bus_req <= '0;
    tick(1);
  endtask
  task automatic rd(input logic [2:0] a);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    tick(1);
    bus_req <= '0;
    tick(1);
    rv = bus_rdata;
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    tick(5);
    reset <= 1'b0;
    tick(1);
  endtask
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int i = 0; i < 8; i++) rev[i] = v[7-i];
  endfunction
  task automatic xfer(input logic [1:0] div, input logic dbl,
                      input logic lsb);
    logic [7:0] d;
    logic [7:0] p;
    int         half;
    int         n;
    d = 8'($urandom);
    p = 8'($urandom);
    exp_q.push_back(lsb ? rev(p) : p);
    half = (div == 2'h3) ? 64 : (2 << (2 * div));
    half = half >> dbl;
    peer_tx <= p;
    load <= 1'b1;
    tick(1);
    load <= 1'b0;
    wr(SHC_OFS_CONTROL_A, {1'b0, lsb, 1'b1, dbl, 1'b0, div, 1'b1});
    wr(SHC_OFS_DATA, d);
    wr(SHC_OFS_DATA, ~d);
    n = 0;
    while (pins_out.sclk_o !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    n = 0;
    while (pins_out.sclk_o === 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    check("half period", 8'(n), 8'(half));
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    check("irq set", {7'h00, irq}, 8'h01);
    rd(SHC_OFS_FLAGS);
    check("flags", rv, 8'hC0);
    rd(SHC_OFS_DATA);
    check("rx data", rv, exp_q.pop_front());
    check("peer data", peer_rx, lsb ? rev(d) : d);
    rd(SHC_OFS_FLAGS);
    check("flags clear", rv, 8'h00);
    check("irq clear", {7'h00, irq}, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 40000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    logic [7:0] r;
    void'($urandom(72925));
    do_reset();
    for (int a = 0; a < 8; a++) begin
      rd(3'(a));
      check("reset value", rv, 8'h00);
    end
    wr(3'h6, 8'hFF);
    rd(3'h6);
    check("unmapped", rv, 8'h00);
    r = 8'($urandom) & 8'hFE;
    wr(SHC_OFS_CONTROL_A, r);
    rd(SHC_OFS_CONTROL_A);
    check("control a", rv, r & SHC_MASK_A);
    r = 8'($urandom) & 8'h7F;
    wr(SHC_OFS_CONTROL_B, r);
    rd(SHC_OFS_CONTROL_B);
    check("control b", rv, r & SHC_MASK_B);
    wr(SHC_OFS_IRQ_EN, 8'hFF);
    rd(SHC_OFS_IRQ_EN);
    check("enables normal", rv, 8'h01);
    wr(SHC_OFS_CONTROL_B, 8'h80);
    rd(SHC_OFS_IRQ_EN);
    check("enables buffered", rv, SHC_MASK_E);
    rd(SHC_OFS_FLAGS);
    check("tx empty", rv, 8'h20);
    wr(SHC_OFS_DATA, 8'h5A);
    rd(SHC_OFS_FLAGS);
    check("tx pending", rv, 8'h00);
    $display("test registers done");
    do_reset();
    wr(SHC_OFS_CONTROL_A, 8'h21);
    for (int m = 0; m < 4; m++) begin
      wr(SHC_OFS_CONTROL_B, 8'(m));
      tick(2);
      check("idle clock", {7'h00, pins_out.sclk_o}, 8'(m >> 1));
      rv = {6'h00, pins_out.sclk_oe, pins_out.mosi_oe};
      check("clock drive", rv, 8'h03);
    end
    wr(SHC_OFS_CONTROL_B, 8'h00);
    wr(SHC_OFS_IRQ_EN, 8'h01);
    for (int i = 0; i < 8; i++) begin
      xfer(2'(i >> 1), i[0], i[1]);
    end
    $display("test transfers done");
    wr(SHC_OFS_CONTROL_A, 8'h21);
    wr(SHC_OFS_CONTROL_B, 8'h04);
    sel_n <= 1'b0;
    tick(4);
    rd(SHC_OFS_CONTROL_A);
    check("host kept", rv, 8'h21);
    wr(SHC_OFS_CONTROL_B, 8'h00);
    tick(4);
    rd(SHC_OFS_CONTROL_A);
    check("host dropped", rv, 8'h01);
    rv = {6'h00, pins_out.miso_oe, pins_out.sclk_oe};
    check("client drive", rv, 8'h02);
    rd(SHC_OFS_FLAGS);
    check("fault done", rv, 8'h80);
    irq_ack <= 1'b1;
    tick(1);
    irq_ack <= 1'b0;
    tick(2);
    check("irq ack", {7'h00, irq}, 8'h00);
    $display("test fallback done");
    finish_test();
  end
endmodule
`default_nettype wire
